// *** amp_channel_status_control_regs.sv ***
// per-channel status and control register bank of the four-channel amplifier
`include "amp_consts.svh"
module amp_channel_status_control_regs
   import amp_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // register port from the serial front end
   input  wire logic [7:0]      reg_addr,
   input  wire logic            reg_wr,
   input  wire logic [7:0]      reg_wdata,
   input  wire logic            reg_rd,
   output logic      [7:0]      reg_rdata,
   output logic                 reg_rvalid,
   // channel state from the power stage, channel 1 in bit 0
   input  wire logic [3:0]      highz_state,
   input  wire logic [3:0]      outp_driven_low,
   input  wire logic [3:0]      outn_driven_low,
   input  wire logic [3:0]      mute_state,
   input  wire logic [3:0]      play_state,
   input  wire logic [3:0]      foldback_state,
   input  wire logic [3:0]      load_check_state,
   // control toward the power stage
   output logic      [7:0]      amp_gain_code,
   output logic      [3:0][7:0] gain_db,
   output logic      [3:0]      current_limit_level,
   output logic                 thermal_foldback_off,
   output logic      [1:0]      switching_freq_code,
   output logic      [9:0]      switching_freq_khz,
   output logic      [5:0]      pin_config
);
   logic [3:0]  highz_sync;
   logic [23:0] other_sync;
   logic [3:0]  grounded_flag;
   logic [3:0]  muted_flag;
   logic [3:0]  playing_flag;
   logic [3:0]  thermal_foldback_flag;
   logic [3:0]  load_check_active;
   reg_byte_t   gain_reg;
   reg_byte_t   oc_reg;
   reg_byte_t   freq_reg;
   reg_byte_t   next_rdata;

   flag_sync #(
      .WIDTH     (4),
      .RESET_VAL ({20'h00000, `AMP_RST_HIGHZ})
   ) u_highz_sync (
      .clk      (clk),
      .rst      (rst),
      .raw      (highz_state),
      .filtered (highz_sync)
   );

   flag_sync #(
      .WIDTH     (24),
      .RESET_VAL ({6{`AMP_RST_FLAGS}})
   ) u_other_sync (
      .clk      (clk),
      .rst      (rst),
      .raw      ({load_check_state, foldback_state, play_state, mute_state,
                  outn_driven_low, outp_driven_low}),
      .filtered (other_sync)
   );

   // grounded needs both halves driven low; one low output alone is not the state
   assign grounded_flag         = other_sync[3:0] & other_sync[7:4];
   assign muted_flag            = other_sync[11:8];
   assign playing_flag          = other_sync[15:12];
   // foldback cannot be reported while it is switched off
   assign thermal_foldback_flag = other_sync[19:16] & {4{~thermal_foldback_off}};
   assign load_check_active     = other_sync[23:20];

   // gain select register
   always_ff @(posedge clk) begin
      if (rst) begin
         gain_reg <= `AMP_RST_GAIN;
      end else if (reg_wr && reg_addr == `AMP_OFS_GAIN) begin
         gain_reg <= reg_wdata;
      end
   end

   // overcurrent control register, reserved bits kept as written
   always_ff @(posedge clk) begin
      if (rst) begin
         oc_reg <= `AMP_RST_OC;
      end else if (reg_wr && reg_addr == `AMP_OFS_OC) begin
         oc_reg <= reg_wdata;
      end
   end

   // frequency / pin configuration; an invalid frequency code keeps the old one
   always_ff @(posedge clk) begin
      if (rst) begin
         freq_reg <= `AMP_RST_FREQ;
      end else if (reg_wr && reg_addr == `AMP_OFS_FREQ) begin
         freq_reg[7:2] <= reg_wdata[7:2];
         if (reg_wdata[1:0] != FREQ_BAD) begin
            freq_reg[1:0] <= reg_wdata[1:0];
         end
      end
   end

   assign amp_gain_code        = gain_reg;
   assign current_limit_level  = oc_reg[`AMP_OC_LIMIT_LSB +: 4];
   assign thermal_foldback_off = oc_reg[`AMP_OC_THFB_BIT];
   assign switching_freq_code  = freq_reg[`AMP_FREQ_LSB +: 2];
   assign pin_config           = freq_reg[`AMP_PIN_CFG_LSB +: 6];

   always_ff @(posedge clk) begin
      if (rst) begin
         gain_db <= {4{`AMP_GAIN_DB_C2}};
      end else begin
         for (int ch = 0; ch < 4; ch++) begin
            case (gain_reg[2*ch +: 2])
               2'b00: gain_db[ch] <= `AMP_GAIN_DB_C0;
               2'b01: gain_db[ch] <= `AMP_GAIN_DB_C1;
               2'b10: gain_db[ch] <= `AMP_GAIN_DB_C2;
               default: gain_db[ch] <= `AMP_GAIN_DB_C3;
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         switching_freq_khz <= `AMP_FREQ_KHZ_C1;
      end else begin
         case (freq_code_t'(freq_reg[1:0]))
            FREQ_500: switching_freq_khz <= `AMP_FREQ_KHZ_C0;
            FREQ_357: switching_freq_khz <= `AMP_FREQ_KHZ_C2;
            default:  switching_freq_khz <= `AMP_FREQ_KHZ_C1;
         endcase
      end
   end

   // read mux; status offsets have no write path at all
   always_comb begin
      next_rdata = 8'h00;
      if (reg_addr == `AMP_OFS_OUT_STATE) begin
         next_rdata = {grounded_flag, highz_sync};
      end else if (reg_addr == `AMP_OFS_PLAY_MUTE) begin
         next_rdata = {muted_flag, playing_flag};
      end else if (reg_addr == `AMP_OFS_FB_DIAG) begin
         next_rdata = {thermal_foldback_flag, load_check_active};
      end else if (reg_addr == `AMP_OFS_GAIN) begin
         next_rdata = gain_reg;
      end else if (reg_addr == `AMP_OFS_OC) begin
         next_rdata = oc_reg;
      end else if (reg_addr == `AMP_OFS_FREQ) begin
         next_rdata = freq_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   reset_values_a: assert property ($past(rst) |-> gain_reg == 8'hAA && oc_reg == 8'hF0
      && freq_reg == 8'h0D && highz_sync == 4'hF && muted_flag == 4'h0)
      else $error("register bank reset values wrong");
   status_write_a: assert property (reg_wr && reg_addr inside {8'h05, 8'h06, 8'h07}
      |=> $stable(gain_reg) && $stable(oc_reg) && $stable(freq_reg))
      else $error("status write disturbed control state");
   // decode is checked against the code one cycle back, so back-to-back writes stay legal
   gain_write_a: assert property (reg_wr && reg_addr == 8'h08
      |=> amp_gain_code == $past(reg_wdata) ##1 gain_db[3] ==
      ($past(amp_gain_code[7:6]) == 2'b00 ? 8'h0C :
       $past(amp_gain_code[7:6]) == 2'b01 ? 8'h14 :
       $past(amp_gain_code[7:6]) == 2'b10 ? 8'h1A : 8'h20))
      else $error("gain field write or decode wrong");
   oc_write_a: assert property (reg_wr && reg_addr == 8'h09
      |=> current_limit_level == $past(reg_wdata[7:4]))
      else $error("current limit select not taken");
   freq_bad_a: assert property (reg_wr && reg_addr == 8'h0A && reg_wdata[1:0] == 2'b11
      |=> $stable(switching_freq_code) && pin_config == $past(reg_wdata[7:2]))
      else $error("invalid frequency code accepted");
   freq_decode_a: assert property (switching_freq_code == 2'b10 && $stable(switching_freq_code)
      |-> switching_freq_khz == 10'h165)
      else $error("357 kHz decode wrong");
   // five samples flush all three stages and the filter register of that pin
   grounded_both_a: assert property ((!outn_driven_low[0]) [*5]
      |-> !grounded_flag[0])
      else $error("grounded reported with one output free");
   foldback_off_a: assert property (reg_rd && reg_addr == 8'h07 && thermal_foldback_off
      |=> reg_rdata[7:4] == 4'h0)
      else $error("foldback shown while disabled");
   read_out_state_a: assert property (reg_rd && reg_addr == 8'h05
      |=> reg_rvalid && reg_rdata == {$past(grounded_flag), $past(highz_sync)})
      else $error("output-state read wrong");
   read_play_mute_a: assert property (reg_rd && reg_addr == 8'h06
      |=> reg_rdata == {$past(muted_flag), $past(playing_flag)})
      else $error("play/mute read wrong");
   read_fb_diag_a: assert property (reg_rd && reg_addr == 8'h07
      |=> reg_rdata == {$past(thermal_foldback_flag), $past(load_check_active)})
      else $error("foldback/diagnostics read wrong");
   highz_follow_a: assert property ($rose(highz_state[0]) ##1 highz_state[0] [*3]
      |-> ##[0:2] highz_sync[0])
      else $error("high impedance flag did not follow");

   gain_write_c: cover property (reg_wr && reg_addr == 8'h08);
   status_read_c: cover property (reg_rd && reg_addr == 8'h05 ##1 reg_rdata[4]);
   bad_freq_c: cover property (reg_wr && reg_addr == 8'h0A && reg_wdata[1:0] == 2'b11);
   foldback_seen_c: cover property (thermal_foldback_flag != 4'h0);
endmodule

// *** amp_channel_status_control_regs_tb.sv ***
// self-checking bench for the channel register bank
`include "amp_consts.svh"
module amp_channel_status_control_regs_tb import amp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, wr, rd, rvalid, tfo;
   logic [7:0] addr, wdata, rdata, gcode;
   logic [3:0][7:0] gdb;
   logic [3:0] hz, op, on, mu, pl, fb, ld, cll;
   logic [1:0] fcode, pc;
   logic [9:0] fkhz;
   logic [5:0] pin;
   reg_byte_t v, t;
   int seed, failures, total_checks, cycles;
   amp_channel_status_control_regs u_dut (.clk(clk), .rst(rst), .reg_addr(addr),
      .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .highz_state(hz), .outp_driven_low(op),
      .outn_driven_low(on), .mute_state(mu), .play_state(pl), .foldback_state(fb),
      .load_check_state(ld), .amp_gain_code(gcode), .gain_db(gdb),
      .current_limit_level(cll), .thermal_foldback_off(tfo),
      .switching_freq_code(fcode), .switching_freq_khz(fkhz), .pin_config(pin));
   amp_host_model u_host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid));
   always #50 clk = ~clk;
   function automatic logic [7:0] exp_db(input logic [1:0] c);
      return (c == 2'h0) ? 8'h0C : (c == 2'h1) ? 8'h14 : (c == 2'h2) ? 8'h1A : 8'h20;
   endfunction
   function automatic logic [9:0] exp_khz(input logic [1:0] c);
      return (c == 2'h0) ? 10'h1F4 : (c == 2'h1) ? 10'h1A1 : 10'h165;
   endfunction
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] ex);
      total_checks++;
      if (seen !== ex) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] ex);
      reg_byte_t d;
      u_host.rd(a, d);
      chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, ex});
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // the whole sequence needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         failures++;
         test_done();
      end
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      seed = 41065;
      {hz, op, on, mu, pl, fb, ld} = {4'hF, 24'h0};
      repeat (6) @(negedge clk);
      rst = 1'b0;
      chk_rd(`AMP_OFS_GAIN, 8'hAA);
      chk_rd(`AMP_OFS_OC, 8'hF0);
      chk_rd(`AMP_OFS_FREQ, 8'h0D);
      chk("khz", {6'h0, fkhz}, 16'h01A1);
      chk_rd(`AMP_OFS_OUT_STATE, 8'h0F);
      chk_rd(`AMP_OFS_PLAY_MUTE, 8'h00);
      chk_rd(`AMP_OFS_FB_DIAG, 8'h00);
      $display("reset test done");
      for (int i = 0; i < 8; i++) begin
         v = (i < 4) ? {4{i[1:0]}} : 8'($random(seed));
         u_host.wr(`AMP_OFS_GAIN, v);
         repeat (2) @(negedge clk);
         chk("gain code", {8'h0, gcode}, {8'h0, v});
         for (int c = 0; c < 4; c++)
            chk("gain db", {8'h0, gdb[c]}, {8'h0, exp_db(v[2*c+:2])});
         chk_rd(`AMP_OFS_GAIN, v);
      end
      for (int i = 0; i < 6; i++) begin
         v = (i < 2) ? {4{i[0], 1'b0}} : 8'($random(seed));
         u_host.wr(`AMP_OFS_OC, v);
         @(negedge clk);
         chk("limit", {12'h0, cll}, {12'h0, v[7:4]});
         chk("fb off", {15'h0, tfo}, {15'h0, v[0]});
         chk_rd(`AMP_OFS_OC, v);
      end
      pc = 2'h1;
      for (int c = 0; c < 4; c++) begin
         t = 8'($random(seed));
         v = {t[7:2], c[1:0]};
         if (c != 3) pc = c[1:0];
         u_host.wr(`AMP_OFS_FREQ, v);
         repeat (2) @(negedge clk);
         chk("freq khz", {6'h0, fkhz}, {6'h0, exp_khz(pc)});
         chk("freq code", {14'h0, fcode}, {14'h0, pc});
         chk("pin cfg", {10'h0, pin}, {10'h0, v[7:2]});
         chk_rd(`AMP_OFS_FREQ, {v[7:2], pc});
      end
      $display("control tests done");
      for (int i = 0; i < 10; i++) begin
         @(negedge clk);
         {hz, op, on, mu} = 16'($random(seed));
         {pl, fb, ld} = 12'($random(seed));
         u_host.wr(`AMP_OFS_OC, {7'h78, i[0]});
         u_host.wr(8'(`AMP_OFS_OUT_STATE + i % 3), 8'($random(seed)));
         repeat (4) @(negedge clk);
         chk_rd(`AMP_OFS_OUT_STATE, {op & on, hz});
         chk_rd(`AMP_OFS_PLAY_MUTE, {mu, pl});
         chk_rd(`AMP_OFS_FB_DIAG, {fb & ~{4{i[0]}}, ld});
      end
      // a reset in mid-run must bring the defaults back over written values
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk_rd(`AMP_OFS_GAIN, 8'hAA);
      chk_rd(`AMP_OFS_OC, 8'hF0);
      chk_rd(`AMP_OFS_FREQ, 8'h0D);
      chk("code after reset", {14'h0, fcode}, 16'h0001);
      chk("db after reset", {8'h0, gdb[3]}, 16'h001A);
      $display("mid-run reset test done");
      u_host.wr(8'h20, 8'h5A);
      chk_rd(8'h20, 8'h00);
      $display("status tests done");
      test_done();
   end
endmodule

// *** amp_consts.svh ***
// constant offsets, field positions, reset values and decode figures of the channel register bank
// Contract
// - Bits 3:0 of the output-state register read 1 for each channel in high impedance, reset 1.
// - The output-state register carries a per-channel grounded-outputs flag, reset 0.
// - A channel is grounded only while both of its outputs are actively driven to ground.
// - Bits 7:4 of the play/mute register show the muted flag of channels 4..1, reset 0.
// - Bits 3:0 of the play/mute register show the playing flag of channels 4..1, reset 0.
// - Bits 7:4 of the foldback/diagnostics register show per-channel thermal foldback, reset 0.
// - Bits 3:0 of the foldback/diagnostics register show per-channel load diagnostics, reset 0.
// - Each two-bit gain field decodes 00/01/10/11 to 12/20/26/32 dB, channel 4 in bits 7:6.
// - Every gain field resets to code 10, which is 26 dB.
// - Bits 7:4 of the overcurrent register pick limit level 1 when 0 and level 2 when 1.
// - Every current-limit bit resets to 1, which is level 2.
// - The switching-frequency field decodes 00/01/10 to 500/417/357 kHz, reset 01, code 11 unused.
`ifndef AMP_CONSTS_SVH
`define AMP_CONSTS_SVH

`define AMP_OFS_OUT_STATE   8'h05
`define AMP_OFS_PLAY_MUTE   8'h06
`define AMP_OFS_FB_DIAG     8'h07
`define AMP_OFS_GAIN        8'h08
`define AMP_OFS_OC          8'h09
`define AMP_OFS_FREQ        8'h0A

`define AMP_RST_GAIN        8'hAA
`define AMP_RST_OC          8'hF0
`define AMP_RST_FREQ        8'h0D
`define AMP_RST_HIGHZ       4'hF
`define AMP_RST_FLAGS       4'h0

`define AMP_OC_LIMIT_LSB    4
`define AMP_OC_THFB_BIT     0
`define AMP_FREQ_LSB        0
`define AMP_PIN_CFG_LSB     2

`define AMP_GAIN_DB_C0      8'h0C
`define AMP_GAIN_DB_C1      8'h14
`define AMP_GAIN_DB_C2      8'h1A
`define AMP_GAIN_DB_C3      8'h20

`define AMP_FREQ_KHZ_C0     10'h1F4
`define AMP_FREQ_KHZ_C1     10'h1A1
`define AMP_FREQ_KHZ_C2     10'h165

`define AMP_SYNC_STAGES     3

`endif

// *** amp_host_model.sv ***
// host model issuing single-byte accesses on the register strobe port
module amp_host_model (
   // clock
   input  wire logic       clk,
   // strobe port
   output logic      [7:0] reg_addr,
   output logic            reg_wr,
   output logic      [7:0] reg_wdata,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      reg_rd = 1'b0;
   end
   // released lines carry the inverse so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 3) begin
         @(negedge clk);
         n++;
      end
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
   endtask
endmodule

// *** amp_pkg.sv ***
// types shared by the channel register bank
package amp_pkg;
   typedef logic [1:0] gain_code_t;
   typedef logic [7:0] reg_byte_t;
   typedef enum logic [1:0] {
      FREQ_500 = 2'b00,
      FREQ_417 = 2'b01,
      FREQ_357 = 2'b10,
      FREQ_BAD = 2'b11
   } freq_code_t;
endpackage

// *** flag_sync.sv ***
// three-stage input synchroniser that accepts a change once stages two and three agree
`include "amp_consts.svh"
module flag_sync #(
   parameter int          WIDTH     = 4,
   parameter logic [23:0] RESET_VAL = 24'h000000
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // raw pins and filtered result
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] filtered
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= RESET_VAL[WIDTH-1:0];
         stage2 <= RESET_VAL[WIDTH-1:0];
         stage3 <= RESET_VAL[WIDTH-1:0];
      end else begin
         stage1 <= raw;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // per bit: a one-cycle glitch that only reached stage two is not taken
   always_ff @(posedge clk) begin
      if (rst) begin
         filtered <= RESET_VAL[WIDTH-1:0];
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
               filtered[i] <= stage3[i];
            end
         end
      end
   end
endmodule
